// file: corr_pkg.sv
// Shared constants and types for the correction table loader.
// Assumes one 250 MHz clock domain and synchronous host inputs.
package corr_pkg;

    // ----------------------------------------------------------------
    // Table geometry
    // ----------------------------------------------------------------
    localparam int unsigned GRID_SIDE   = 65;
    localparam int unsigned SECTION_LEN = 4225;
    localparam int unsigned XY_LEN      = 8450;
    localparam int unsigned TABLE_LEN   = 12675;
    localparam int unsigned GRID_SHIFT  = 10;     // Grid pitch 1024
    localparam int unsigned IDX_W       = 14;
    localparam int unsigned WORD_W      = 16;
    localparam logic [16:0] HALF_PITCH  = 17'h0_0200;
    localparam logic [6:0]  LAST_COL    = 7'h40;

    // ----------------------------------------------------------------
    // Power-up scan defaults
    // ----------------------------------------------------------------
    localparam logic [15:0] DEF_MARK_STEP = 16'h0020;   // 32 LSB
    localparam logic [15:0] DEF_JUMP_STEP = 16'h0200;   // 512 LSB

    // ----------------------------------------------------------------
    // Host words and positions
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DATA_WORD          = 3'h0,
        load_table_cmd     = 3'h1,
        quit_table_cmd     = 3'h2,
        clear_table_cmd    = 3'h3,
        mark_step_size_cmd = 3'h4,
        jump_step_size_cmd = 3'h5
    } cmd_t;

    typedef struct packed {
        cmd_t        cmd;
        logic [15:0] data;
    } hostWord_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } position_t;

endpackage : corr_pkg

// file: table_memory.sv
// Correction store: single write port, registered read port.
// Assumes no reset reaches the array, so contents survive reset.
`timescale 1ns/10ps
`default_nettype none
module table_memory #(
    parameter int unsigned DEPTH = 12675,
    parameter int unsigned AW    = 14,
    parameter int unsigned DW    = 16
) (
    input  wire logic          clk,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic [AW-1:0] rdAddr,
    output var  logic [DW-1:0] rdData
);

    logic [DW-1:0] mem [DEPTH];

    // Depth must fit the address
    if (DEPTH > (1 << AW)) begin : gBadDepth
        $error("table_memory: DEPTH exceeds address range");
    end

    // Write and registered read, no reset
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule : table_memory
`default_nettype wire

// file: nearest_grid.sv
// Maps a commanded X,Y position to the nearest grid point index.
// Purely combinational; assumes the 65 by 65 grid at pitch 1024.
`timescale 1ns/10ps
`default_nettype none
module nearest_grid (
    input  wire logic [15:0]                posX,
    input  wire logic [15:0]                posY,
    output var  logic [corr_pkg::IDX_W-1:0] gridIdx
);
    import corr_pkg::*;

    logic [16:0] roundX;
    logic [16:0] roundY;
    logic [6:0]  col;
    logic [6:0]  row;

    // Round to nearest pitch, clamp to the last column and row
    always_comb begin
        roundX  = {1'b0, posX} + HALF_PITCH;
        roundY  = {1'b0, posY} + HALF_PITCH;
        col     = roundX[16:GRID_SHIFT];
        row     = roundY[16:GRID_SHIFT];
        if (col > LAST_COL) col = LAST_COL;
        if (row > LAST_COL) row = LAST_COL;
        gridIdx = IDX_W'(row * GRID_SIDE + col);
    end

endmodule : nearest_grid
`default_nettype wire

// file: correction_table_loader.sv
// Command interpreter that loads, clears and applies the correction
// table and holds the scan step defaults.
// Assumes synchronous host words and one clock; table kept over reset.
//
// Operation
// [R01] Store is Y, X, Z sections of 4225
// [R02] Incoming values fill Y, then X, then Z
// [R03] Load of 8450 values counts as complete
// [R04] Entries run row by row, X fastest
// [R05] Point 65535,65535 ends each section
// [R06] Receive mode entered only by load command
// [R07] Quit command returns to normal commands
// [R08] Host may embed load and quit commands
// [R09] Host keeps corrected positions inside range
// [R10] Edge deltas point inward or are zero
// [R11] Interior deltas never exceed edge distance
// [R12] Scan parameters take defaults at reset
// [R13] Marking step defaults to 32 LSB
// [R14] Jump step defaults to 512 LSB
// [R15] Table survives reset untouched
// [R16] Clear command zeroes every table entry
// [R17] No correction until a grid arrives
// [R18] Each value goes to next sequential index
// [R19] Add nearest grid delta; Z is focus
`timescale 1ns/10ps
`default_nettype none
module correction_table_loader #(
    parameter int unsigned DEPTH = 12675
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                powerOnRst_b,
    input  wire logic                hostValid,
    input  wire corr_pkg::hostWord_t hostWord,
    output var  logic                hostReady,
    input  wire logic                posValid,
    input  wire logic [15:0]         posX,
    input  wire logic [15:0]         posY,
    output var  logic                posReady,
    output var  logic                outValid,
    output var  corr_pkg::position_t outPos,
    output var  logic [15:0]         markStep,
    output var  logic [15:0]         jumpStep,
    output var  logic                tableLoading,
    output var  logic                tableValid,
    output var  logic                focusValid,
    output var  logic [13:0]         loadCount
);
    import corr_pkg::*;

    // ----------------------------------------------------------------
    // Types and checks
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        IDLE   = 7'b000_0001,
        LOAD   = 7'b000_0010,
        CLEAR  = 7'b000_0100,
        READ_Y = 7'b000_1000,
        READ_X = 7'b001_0000,
        READ_Z = 7'b010_0000,
        EMIT   = 7'b100_0000
    } state_t;

    typedef struct packed {
        state_t           state;
        logic [IDX_W-1:0] count;
        logic [IDX_W-1:0] grid;
        logic [15:0]      markStep;
        logic [15:0]      jumpStep;
        logic [15:0]      posX;
        logic [15:0]      posY;
        logic [15:0]      deltaY;
        logic [15:0]      deltaX;
        logic             outValid;
        position_t        outPos;
    } ctrl_t;

    // Flags that rst_b leaves alone; power-on reset and clear command zero them
    typedef struct packed {
        logic tableValid;
        logic focusValid;
    } keep_t;

    if (DEPTH != TABLE_LEN) begin : gBadDepth
        $error("correction_table_loader: DEPTH must be TABLE_LEN");
    end

    // Three equal sections of one square grid each [R01]
    if (GRID_SIDE * GRID_SIDE != SECTION_LEN) begin : gBadGrid
        $error("correction_table_loader: grid and section disagree");
    end
    if (XY_LEN != 2 * SECTION_LEN) begin : gBadXy
        $error("correction_table_loader: XY_LEN is not two sections");
    end
    if (TABLE_LEN != 3 * SECTION_LEN) begin : gBadTable
        $error("correction_table_loader: TABLE_LEN is not three sections");
    end
    // Counter must reach one past the last index
    if (TABLE_LEN >= (1 << IDX_W)) begin : gBadIndex
        $error("correction_table_loader: IDX_W too narrow for table");
    end

    localparam logic [IDX_W-1:0] SEC1 = IDX_W'(SECTION_LEN);
    localparam logic [IDX_W-1:0] SEC2 = IDX_W'(XY_LEN);
    localparam logic [IDX_W-1:0] LAST = IDX_W'(TABLE_LEN - 1);
    localparam logic [IDX_W-1:0] FULL = IDX_W'(TABLE_LEN);

    ctrl_t            cur;
    ctrl_t            next_cur;
    keep_t            keep;
    keep_t            next_keep;
    logic             wrEn;
    logic [IDX_W-1:0] wrAddr;
    logic [15:0]      wrData;
    logic [IDX_W-1:0] rdAddr;
    logic [15:0]      rdData;
    logic [IDX_W-1:0] gridIdx;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    // Store without reset, so contents outlive rst_b
    table_memory #(
        .DEPTH (DEPTH),
        .AW    (IDX_W),
        .DW    (WORD_W)
    ) uStore (
        .clk    (clk),
        .wrEn   (wrEn),
        .wrAddr (wrAddr),
        .wrData (wrData),
        .rdAddr (rdAddr),
        .rdData (rdData)
    ); // [R15]

    // Nearest grid point of the commanded position
    nearest_grid uGrid (
        .posX    (posX),
        .posY    (posY),
        .gridIdx (gridIdx)
    );

    // ----------------------------------------------------------------
    // Handshakes and outputs
    // ----------------------------------------------------------------
    // Host words taken only while idle or receiving
    assign hostReady    = (cur.state == IDLE) || (cur.state == LOAD);
    // Host words take priority over positions
    assign posReady     = (cur.state == IDLE) && !hostValid;
    assign outValid     = cur.outValid;
    assign outPos       = cur.outPos;
    assign markStep     = cur.markStep;
    assign jumpStep     = cur.jumpStep;
    assign tableLoading = (cur.state == LOAD);
    assign tableValid   = keep.tableValid;
    assign focusValid   = keep.focusValid;
    assign loadCount    = cur.count;

    // ----------------------------------------------------------------
    // Store port steering
    // ----------------------------------------------------------------
    always_comb begin
        wrEn   = 1'b0;
        wrAddr = cur.count;
        wrData = hostWord.data;
        rdAddr = cur.grid;
        // Received values go to the next index in order
        if (cur.state == LOAD && hostValid
            && hostWord.cmd == DATA_WORD && cur.count < FULL) begin
            wrEn = 1'b1; // [R18] [R02] [R04]
        end
        // Sweep writes zero to every entry
        if (cur.state == CLEAR) begin
            wrEn   = 1'b1;
            wrData = '0; // [R16]
        end
        // Y section, then X, then Z of the same grid point
        unique case (1'b1)
            cur.state == READ_X: rdAddr = cur.grid + SEC1; // [R01]
            cur.state == READ_Z: rdAddr = cur.grid + SEC2; // [R01]
            default:             rdAddr = cur.grid;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_cur          = cur;
        next_keep         = keep;
        next_cur.outValid = 1'b0;
        unique case (cur.state)
            IDLE: begin
                if (hostValid) begin
                    unique case (hostWord.cmd)
                        load_table_cmd: begin
                            next_cur.state = LOAD; // [R06]
                            next_cur.count = '0;
                        end
                        clear_table_cmd: begin
                            next_cur.state     = CLEAR;
                            next_cur.count     = '0;
                            next_keep          = '0;
                        end
                        mark_step_size_cmd: begin
                            next_cur.markStep = hostWord.data; // [R13]
                        end
                        jump_step_size_cmd: begin
                            next_cur.jumpStep = hostWord.data; // [R14]
                        end
                        // Stray data and quit ignored outside receive
                        default: begin
                        end
                    endcase
                end else if (posValid) begin
                    next_cur.posX = posX;
                    next_cur.posY = posY;
                    next_cur.grid = gridIdx;
                    if (keep.tableValid) begin
                        next_cur.state = READ_Y;
                    end else begin
                        // Uncorrected pass-through
                        next_cur.outValid = 1'b1; // [R17]
                        next_cur.outPos   = '{posX, posY, 16'h0000};
                    end
                end
            end
            LOAD: begin
                if (hostValid) begin
                    if (hostWord.cmd == quit_table_cmd) begin
                        next_cur.state = IDLE; // [R07]
                        // Y and X sections alone are a whole load
                        next_keep.tableValid = cur.count >= SEC2; // [R03]
                        next_keep.focusValid = cur.count == FULL;
                    end else if (hostWord.cmd == DATA_WORD
                                 && cur.count < FULL) begin
                        // Index 4224, 8449 close Y and X sections
                        next_cur.count = cur.count + 1'b1; // [R05]
                    end
                end
            end
            CLEAR: begin
                // One entry per clock until the last index
                next_cur.count = cur.count + 1'b1;
                if (cur.count == LAST) begin
                    next_cur.state = IDLE; // [R16]
                    next_cur.count = '0;
                end
            end
            READ_Y: begin
                next_cur.state = READ_X;
            end
            READ_X: begin
                next_cur.deltaY = rdData;
                next_cur.state  = READ_Z;
            end
            READ_Z: begin
                next_cur.deltaX = rdData;
                next_cur.state  = EMIT;
            end
            EMIT: begin
                // Wrap of the sum is left to the host's deltas
                next_cur.outPos.x = cur.posX + cur.deltaX; // [R19] [R09]
                next_cur.outPos.y = cur.posY + cur.deltaY; // [R19] [R10]
                next_cur.outPos.z = keep.focusValid ? rdData
                                                    : 16'h0000; // [R19]
                next_cur.outValid = 1'b1; // [R11]
                next_cur.state    = IDLE;
            end
            default: begin
                next_cur.state = IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Control state; step sizes return to defaults on reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur          <= '0;
            cur.state    <= IDLE;
            cur.markStep <= DEF_MARK_STEP; // [R12] [R13]
            cur.jumpStep <= DEF_JUMP_STEP; // [R12] [R14]
        end else begin
            cur <= next_cur;
        end
    end

    // Table flags cleared at power-on or by clear command, kept over rst_b
    always_ff @(posedge clk or negedge powerOnRst_b) begin
        if (!powerOnRst_b) begin
            keep <= '0; // [R17]
        end else begin
            keep <= next_keep; // [R15]
        end
    end

endmodule : correction_table_loader
`default_nettype wire

// file: correction_table_loader_sva.sv
// Checker for the correction table loader, watching top ports only.
// Assumes one clock domain; bound into every loader instance below.
`timescale 1ns/10ps
`default_nettype none
module correction_table_loader_sva #(
    parameter int unsigned DEPTH = 12675
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                hostValid,
    input  wire corr_pkg::hostWord_t hostWord,
    input  wire logic                hostReady,
    input  wire logic                posValid,
    input  wire logic [15:0]         posX,
    input  wire logic [15:0]         posY,
    input  wire logic                posReady,
    input  wire logic                outValid,
    input  wire corr_pkg::position_t outPos,
    input  wire logic [15:0]         markStep,
    input  wire logic [15:0]         jumpStep,
    input  wire logic                tableLoading,
    input  wire logic                tableValid,
    input  wire logic                focusValid,
    input  wire logic [13:0]         loadCount
);
    import corr_pkg::*;
    logic take;
    logic takeP;
    // Accepted host word and accepted position
    assign take  = hostValid && hostReady;
    assign takeP = posValid && posReady;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    step_default_a: assert property (
        $rose(rst_b) |-> markStep == 16'h0020 && jumpStep == 16'h0200)
        else $error("step defaults wrong after reset");
    load_enter_a: assert property (
        !tableLoading && take && hostWord.cmd == load_table_cmd
        |=> tableLoading && loadCount == 14'h0000)
        else $error("load command did not open receive mode");
    idle_data_a: assert property (
        !tableLoading && take && hostWord.cmd == DATA_WORD
        |=> !tableLoading && $stable(loadCount))
        else $error("data word accepted outside receive mode");
    count_step_a: assert property (
        tableLoading && take && hostWord.cmd == DATA_WORD
        && loadCount < 14'(DEPTH) |=> loadCount == $past(loadCount) + 14'h0001)
        else $error("load count did not advance by one");
    quit_leave_a: assert property (
        tableLoading && take && hostWord.cmd == quit_table_cmd |=> !tableLoading
        && tableValid == ($past(loadCount) >= 14'h2102)
        && focusValid == ($past(loadCount) == 14'h3183))
        else $error("quit gave wrong mode or validity");
    clear_zero_a: assert property (
        !tableLoading && take && hostWord.cmd == clear_table_cmd
        |=> !hostReady && !tableValid && !focusValid)
        else $error("clear did not start or drop validity");
    uncorr_pass_a: assert property (
        takeP && !tableValid |=> outValid && outPos.z == 16'h0000
        && outPos.x == $past(posX) && outPos.y == $past(posY))
        else $error("uncorrected position altered");
    corr_latency_a: assert property (
        takeP && tableValid |=> !outValid [*4] ##1 outValid)
        else $error("corrected result at wrong cycle");
    jump_set_a: assert property (
        !tableLoading && take && hostWord.cmd == jump_step_size_cmd
        |=> jumpStep == $past(hostWord.data))
        else $error("jump step not taken");
    mark_set_a: assert property (
        !tableLoading && take && hostWord.cmd == mark_step_size_cmd
        |=> markStep == $past(hostWord.data))
        else $error("mark step not taken");
    cover property (take && hostWord.cmd == quit_table_cmd);
    cover property (takeP && tableValid);
    cover property (take && hostWord.cmd == clear_table_cmd);
endmodule : correction_table_loader_sva

bind correction_table_loader correction_table_loader_sva #(.DEPTH(DEPTH))
    sva_i (.clk(clk), .rst_b(rst_b), .hostValid(hostValid),
    .hostWord(hostWord), .hostReady(hostReady), .posValid(posValid),
    .posX(posX), .posY(posY), .posReady(posReady), .outValid(outValid),
    .outPos(outPos), .markStep(markStep), .jumpStep(jumpStep),
    .tableLoading(tableLoading), .tableValid(tableValid),
    .focusValid(focusValid), .loadCount(loadCount));
`default_nettype wire

// file: host_model.sv
// Host model: sends commands and correction words to the loader.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic                clk,
    input  wire logic                hostReady,
    output var  logic                hostValid,
    output var  corr_pkg::hostWord_t hostWord
);
    import corr_pkg::*;
    initial begin
        hostValid = 1'b0;
        hostWord  = '0;
    end
    // Zero Y and X delta on edges, small positive delta inside; Z is 16'h1000 plus point
    function automatic logic [15:0] entry(input int idx);
        int p;
        p = idx % 4225;
        if (idx >= 8450) return 16'h1000 + 16'(p);
        if (p % 65 == 0 || p % 65 == 64 || p < 65 || p >= 4160) return '0;
        return 16'((idx / 4225) * 16 + p % 16 + 1);
    endfunction : entry
    // Word held until a rising edge sees ready high
    task automatic send(input cmd_t c, input logic [15:0] d);
        hostValid <= 1'b1;
        hostWord  <= '{cmd: c, data: d};
        @(negedge clk);
        while (!hostReady) @(negedge clk);
        @(posedge clk);
    endtask : send
    // Released data lines stop showing the last value
    task automatic release_bus();
        hostValid     <= 1'b0;
        hostWord.data <= ~hostWord.data;
    endtask : release_bus
    // Load, Y then X then Z row by row, quit
    task automatic load(input int n);
        send(load_table_cmd, 16'h0000);
        for (int i = 0; i < n; i++) send(DATA_WORD, entry(i));
        send(quit_table_cmd, 16'h0000);
        release_bus();
    endtask : load
endmodule : host_model
`default_nettype wire

// file: correction_table_loader_bench.sv
// Testbench: loads, applies, keeps and clears the correction table.
// Assumes the host model drives host words; bench drives positions.
`timescale 1ns/10ps
`default_nettype none
module correction_table_loader_bench;
    import corr_pkg::*;
    localparam logic [15:0] X0 = 16'h0C64;  // Near grid column 3
    localparam logic [15:0] Y0 = 16'h079C;  // Near grid row 2
    localparam int          P  = 133;
    logic        clk, rst_b, powerOnRst_b, hostValid, hostReady;
    logic        posValid, posReady, outValid, tableLoading;
    logic        tableValid, focusValid;
    logic [15:0] posX, posY, markStep, jumpStep;
    logic [13:0] loadCount;
    hostWord_t   hostWord;
    position_t   outPos, res;
    int          nFail = 0, totalChecks = 0, cycles = 0;

    correction_table_loader correction_table_loader_i (.clk(clk),
        .rst_b(rst_b), .powerOnRst_b(powerOnRst_b), .hostValid(hostValid),
        .hostWord(hostWord), .hostReady(hostReady), .posValid(posValid),
        .posX(posX), .posY(posY), .posReady(posReady), .outValid(outValid),
        .outPos(outPos), .markStep(markStep), .jumpStep(jumpStep),
        .tableLoading(tableLoading), .tableValid(tableValid),
        .focusValid(focusValid), .loadCount(loadCount));
    host_model host_model_i (.clk(clk), .hostReady(hostReady),
        .hostValid(hostValid), .hostWord(hostWord));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            nFail++;
            endSim();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : endSim
    task automatic rst_pulse();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : rst_pulse
    // Offer a position, then catch the result pulse within ten cycles
    task automatic put_pos(input logic [15:0] x, input logic [15:0] y,
                           output position_t r);
        int n;
        posValid <= 1'b1;
        posX     <= x;
        posY     <= y;
        @(negedge clk);
        while (!posReady) @(negedge clk);
        @(posedge clk);
        posValid <= 1'b0;
        n = 0;
        @(negedge clk);
        while (outValid !== 1'b1 && n < 10) begin
            n++;
            @(negedge clk);
        end
        chk(outValid, 1'b1);
        r = outPos;
        @(posedge clk);
    endtask : put_pos

    task automatic t_reset();
        @(negedge clk);
        chk({markStep, jumpStep}, {16'h0020, 16'h0200});
        chk({tableLoading, tableValid, loadCount}, '0);
        @(posedge clk);
        put_pos(X0, Y0, res);
        chk(res, {X0, Y0, 16'h0000});
        host_model_i.send(DATA_WORD, 16'h1234);
        host_model_i.release_bus();
        @(negedge clk);
        chk({tableLoading, loadCount}, '0);
        @(posedge clk);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_steps();
        host_model_i.send(mark_step_size_cmd, 16'h007A);
        host_model_i.send(jump_step_size_cmd, 16'h0104);
        host_model_i.release_bus();
        @(negedge clk);
        chk({markStep, jumpStep}, {16'h007A, 16'h0104});
        @(posedge clk);
        rst_pulse();
        @(negedge clk);
        chk({markStep, jumpStep}, {16'h0020, 16'h0200});
        @(posedge clk);
        $display("t_steps done");
    endtask : t_steps
    task automatic t_load_xy();
        host_model_i.load(8450);
        @(negedge clk);
        chk({tableValid, focusValid, tableLoading, loadCount},
            {3'b100, 14'h2102});
        @(posedge clk);
        put_pos(X0, Y0, res);
        chk(res, {X0 + host_model_i.entry(4225 + P),
                  Y0 + host_model_i.entry(P), 16'h0000});
        $display("t_load_xy done");
    endtask : t_load_xy
    task automatic t_load_full();
        host_model_i.load(12677);
        @(negedge clk);
        chk({tableValid, focusValid, loadCount}, {2'b11, 14'h3183});
        @(posedge clk);
        put_pos(16'hFFFF, 16'hFFFF, res);
        chk(res, {32'hFFFF_FFFF, host_model_i.entry(12674)});
        put_pos(X0, Y0, res);
        chk(res.z, host_model_i.entry(8450 + P));
        $display("t_load_full done");
    endtask : t_load_full
    task automatic t_keep();
        rst_pulse();
        @(negedge clk);
        chk({tableValid, focusValid}, 2'b11);
        @(posedge clk);
        put_pos(X0, Y0, res);
        chk(res.z, host_model_i.entry(8450 + P));
        host_model_i.load(100);
        @(negedge clk);
        chk(tableValid, 1'b0);
        @(posedge clk);
        $display("t_keep done");
    endtask : t_keep
    task automatic t_clear();
        int n;
        host_model_i.send(clear_table_cmd, 16'h0000);
        host_model_i.release_bus();
        @(negedge clk);
        chk({hostReady, tableValid, posReady}, 3'b000);
        n = 0;
        while (hostReady !== 1'b1 && n < 13000) begin
            n++;
            @(negedge clk);
        end
        chk(hostReady, 1'b1);
        @(posedge clk);
        put_pos(X0, Y0, res);
        chk(res, {X0, Y0, 16'h0000});
        $display("t_clear done");
    endtask : t_clear

    initial begin
        rst_b        = 1'b0;
        powerOnRst_b = 1'b0;
        posValid     = 1'b0;
        posX         = '0;
        posY         = '0;
        repeat (4) @(posedge clk);
        rst_b        <= 1'b1;
        powerOnRst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_steps();
        t_load_xy();
        t_load_full();
        t_keep();
        t_clear();
        endSim();
    end
endmodule : correction_table_loader_bench
`default_nettype wire
